// ==== rjl_pkg.sv ====
// Purpose: Shared constants and types for the register jump and load decode slice
// Assumes: 32-bit general registers, 64-bit memory return path
// Notes:   Register offsets are byte addresses on the register bus
package rjl_pkg;

  localparam int          XLEN          = 32;
  localparam int          DLEN          = 64;

  // Primary opcode and function fields
  localparam logic [5:0]  OP_FUNC_GROUP = 6'h00;
  localparam logic [5:0]  FN_JUMP_REG   = 6'h08;
  localparam logic [5:0]  OP_LOAD_LL    = 6'h30;
  localparam logic [5:0]  OP_LOAD_DFP   = 6'h35;
  localparam logic [5:0]  OP_LOAD_DC2   = 6'h36;
  localparam logic [9:0]  JR_ZERO_FIELD = 10'h000;
  localparam logic [4:0]  HINT_DEFAULT  = 5'h00;

  // Register map
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam logic [3:0]  REG_BADADDR   = 4'h8;
  localparam logic [3:0]  REG_TARGET    = 4'hC;

  // Control register fields
  localparam int          CTRL_W        = 5;
  localparam int          CTRL_CC_BIT   = 0;
  localparam int          CTRL_BE_BIT   = 1;
  localparam int          CTRL_FLIP_BIT = 2;
  localparam int          CTRL_CU1_BIT  = 3;
  localparam int          CTRL_CU2_BIT  = 4;
  localparam logic [4:0]  CTRL_RST      = 5'h18;

  // Status register fields
  localparam int          ST_ISA_BIT    = 0;
  localparam int          ST_LINK_BIT   = 1;
  localparam int          ST_DLY_BIT    = 2;
  localparam int          ST_EXC_LSB    = 8;

  typedef enum logic [3:0] {
    EXC_NONE      = 4'h0,
    EXC_ADDR_LOAD = 4'h1,
    EXC_ADDR_FET  = 4'h2,
    EXC_TLB_REFIL = 4'h3,
    EXC_TLB_INVAL = 4'h4,
    EXC_COP_UNUSE = 4'h5,
    EXC_RESERVED  = 4'h6
  } rjl_exc_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2,
    SZ_DBL  = 2'h3
  } rjl_size_t;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_LBS  = 3'h1,
    K_LBU  = 3'h2,
    K_LHS  = 3'h3,
    K_LHU  = 3'h4,
    K_LLW  = 3'h5,
    K_LDF  = 3'h6,
    K_LOAD_DOUBLE_TO_COP_TWO = 3'h7
  } rjl_kind_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_MEM  = 2'h1
  } rjl_state_t;

  typedef struct packed {
    logic             valid;
    logic [XLEN-1:0]  addr;
    rjl_size_t        size;
  } rjl_mem_req_t;

  typedef struct packed {
    logic             valid;
    logic [DLEN-1:0]  data;
    logic             tlb_refill;
    logic             tlb_invalid;
  } rjl_mem_rsp_t;

  typedef struct packed {
    logic             we;
    logic [4:0]       idx;
    logic [DLEN-1:0]  data;
  } rjl_wb_t;

endpackage

// ==== rjl_decode.sv ====
// Purpose: Decode and execute register jump and byte, halfword, doubleword and linked loads
// Assumes: One instruction in flight; memory side returns aligned data one beat per request
// Notes:   Avalon-MM slave with waitrequest holds control and status
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module rjl_decode #(
  parameter logic [5:0] P_OP_LBS = 6'h20,
  parameter logic [5:0] P_OP_LHS = 6'h21,
  parameter logic [5:0] P_OP_LBU = 6'h24,
  parameter logic [5:0] P_OP_LHU = 6'h25
) (
  // Clock and reset
  input  wire logic                 MCLK,
  input  wire logic                 RESET,
  // Register bus
  input  wire logic [3:0]           AVS_ADDRESS,
  input  wire logic                 AVS_READ,
  input  wire logic                 AVS_WRITE,
  input  wire logic [31:0]          AVS_WRITEDATA,
  input  wire logic [3:0]           AVS_BYTEENABLE,
  output var  logic [31:0]          AVS_READDATA,
  output var  logic                 AVS_WAITREQUEST,
  // Instruction issue
  input  wire logic                 ISSUE_VALID,
  input  wire logic [31:0]          ISSUE_INSTR,
  input  wire logic [31:0]          ISSUE_RS_VAL,
  output var  logic                 ISSUE_READY,
  // Memory side
  output var  rjl_pkg::rjl_mem_req_t MEM_REQ,
  input  wire rjl_pkg::rjl_mem_rsp_t MEM_RSP,
  // Write back
  output var  rjl_pkg::rjl_wb_t     GPR_WB,
  output var  rjl_pkg::rjl_wb_t     FPR_WB,
  output var  rjl_pkg::rjl_wb_t     COP2_WB,
  // Flow and exceptions
  output var  logic                 PC_LOAD,
  output var  logic [31:0]          PC_TARGET,
  output var  logic                 INSTRUCTION_SET_MODE_BIT,
  output var  logic                 LINK_FLAG,
  output var  logic                 EXC_VALID,
  output var  rjl_pkg::rjl_exc_t    EXC_CODE,
  output var  logic [31:0]          EXC_BADADDR
);
  import rjl_pkg::*;

  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  function automatic logic [1:0] lane_of(input logic [1:0] lo, input logic be, input logic half);
    lane_of = lo ^ {be, be & ~half};
  endfunction

  // State
  rjl_state_t         state_r, state_nxt;
  logic [CTRL_W-1:0]  ctrl_r;
  logic               wait_r;
  logic [31:0]        rdata_r;
  logic               isa_r;
  logic               link_r;
  logic               dly_r;
  logic [31:0]        tgt_r;
  logic               tgt_fault_r;
  logic               tgt_isa_r;
  logic [31:0]        va_r;
  rjl_kind_t          kind_r;
  logic [4:0]         dest_r;
  logic               slot_r;
  rjl_exc_t           last_exc_r;
  rjl_mem_req_t       mreq_r;
  rjl_wb_t            gwb_r, fwb_r, cwb_r;
  logic               pcl_r;
  logic [31:0]        pct_r;
  logic               excv_r;
  rjl_exc_t           excc_r;
  logic [31:0]        excb_r;
  logic               ready_r;

  // Field decode
  wire logic [5:0]   opc      = ISSUE_INSTR[31:26];
  wire logic [5:0]   fnc      = ISSUE_INSTR[5:0];
  wire logic [4:0]   rt_fld   = ISSUE_INSTR[20:16];
  wire logic [4:0]   hint_fld = ISSUE_INSTR[10:6];
  wire logic         cc_on    = ctrl_r[CTRL_CC_BIT];
  wire logic         be_on    = ctrl_r[CTRL_BE_BIT];
  wire logic         flip_on  = ctrl_r[CTRL_FLIP_BIT];
  wire logic         cu1_on   = ctrl_r[CTRL_CU1_BIT];
  wire logic         cu2_on   = ctrl_r[CTRL_CU2_BIT];
  wire logic         is_grp   = (opc == OP_FUNC_GROUP) && (fnc == FN_JUMP_REG);
  wire logic         jr_ok    = is_grp && (ISSUE_INSTR[20:11] == JR_ZERO_FIELD);
  wire logic         jr_bad   = is_grp && !jr_ok;
  wire logic         hint_dft = (hint_fld == HINT_DEFAULT);

  wire rjl_kind_t    kind_dec = (opc == P_OP_LBS)    ? K_LBS :
                                (opc == P_OP_LBU)    ? K_LBU :
                                (opc == P_OP_LHS)    ? K_LHS :
                                (opc == P_OP_LHU)    ? K_LHU :
                                (opc == OP_LOAD_LL)  ? K_LLW :
                                (opc == OP_LOAD_DFP) ? K_LDF :
                                (opc == OP_LOAD_DC2) ? K_LOAD_DOUBLE_TO_COP_TWO : K_NONE;

  wire logic [31:0]  ea       = ISSUE_RS_VAL + sext16(ISSUE_INSTR[15:0]);
  wire logic         is_half  = (kind_dec == K_LHS) || (kind_dec == K_LHU);
  wire logic         is_dbl   = (kind_dec == K_LDF) || (kind_dec == K_LOAD_DOUBLE_TO_COP_TWO);
  wire logic         mis_half = is_half && ea[0];
  wire logic         mis_word = (kind_dec == K_LLW) && (ea[1:0] != 2'h0);
  wire logic         mis_dbl  = is_dbl && (ea[2:0] != 3'h0);
  wire logic         mis_any  = mis_half || mis_word || mis_dbl;
  wire logic         cu_bad   = ((kind_dec == K_LDF) && !cu1_on) || ((kind_dec == K_LOAD_DOUBLE_TO_COP_TWO) && !cu2_on);

  wire rjl_size_t    size_dec = is_dbl ? SZ_DBL :
                                (kind_dec == K_LLW) ? SZ_WORD :
                                is_half ? SZ_HALF : SZ_BYTE;

  // Physical low bits flipped for sub-word accesses
  wire logic [1:0]   pflip    = (size_dec == SZ_BYTE) ? {2{flip_on}} :
                                (size_dec == SZ_HALF) ? {flip_on, 1'b0} : 2'h0;

  // Jump target and later fetch check
  wire logic [31:0]  jt_val   = cc_on ? {ISSUE_RS_VAL[31:1], 1'b0} : ISSUE_RS_VAL;
  wire logic         jt_fault = cc_on ? (!ISSUE_RS_VAL[0] && ISSUE_RS_VAL[1]) :
                                        (ISSUE_RS_VAL[1:0] != 2'h0);

  // Issue handshake outcomes
  // A jump in the delay slot counts as the slot instruction
  wire logic         take     = ISSUE_VALID && ready_r;
  wire logic         t_jump   = take && jr_ok && !dly_r;
  wire logic         t_ri     = take && jr_bad;
  wire logic         t_cu     = take && !is_grp && cu_bad;
  wire logic         t_ade    = take && !is_grp && !cu_bad && mis_any;
  wire logic         t_load   = take && !is_grp && (kind_dec != K_NONE) && !cu_bad && !mis_any;
  wire logic         t_other  = take && !jr_bad && !t_jump && (kind_dec == K_NONE || is_grp);

  // Lane selection on returned data
  wire logic [1:0]   bl       = lane_of(va_r[1:0], be_on, 1'b0);
  wire logic [1:0]   hl       = lane_of(va_r[1:0], be_on, 1'b1);
  wire logic [31:0]  mword    = MEM_RSP.data[31:0];
  wire logic [7:0]   byte_v   = mword[8*bl +: 8];
  wire logic [15:0]  half_v   = mword[8*hl +: 16];
  wire logic         rsp_ok   = (state_r == S_MEM) && MEM_RSP.valid && !MEM_RSP.tlb_refill && !MEM_RSP.tlb_invalid;
  wire logic         rsp_flt  = (state_r == S_MEM) && MEM_RSP.valid && (MEM_RSP.tlb_refill || MEM_RSP.tlb_invalid);
  wire rjl_exc_t     tlb_code = MEM_RSP.tlb_refill ? EXC_TLB_REFIL : EXC_TLB_INVAL;

  wire logic [31:0]  gpr_val  = (kind_r == K_LBS) ? {{24{byte_v[7]}}, byte_v} :
                                (kind_r == K_LBU) ? {24'h000000, byte_v} :
                                (kind_r == K_LHS) ? {{16{half_v[15]}}, half_v} :
                                (kind_r == K_LHU) ? {16'h0000, half_v} : mword;

  // Completion of the delay slot instruction
  wire logic         slot_ok  = (t_other && dly_r) || (rsp_ok && slot_r);
  wire logic         slot_err = ((t_ri || t_cu || t_ade) && dly_r) || (rsp_flt && slot_r);

  // Register bus decode
  wire logic         bus_req  = AVS_READ || AVS_WRITE;
  wire logic         bus_wr   = AVS_WRITE && !wait_r && AVS_BYTEENABLE[0];
  wire logic         wr_ctrl  = bus_wr && (AVS_ADDRESS == REG_CTRL);
  wire logic         clr_link = bus_wr && (AVS_ADDRESS == REG_STATUS) && AVS_WRITEDATA[ST_LINK_BIT];
  wire logic [31:0]  st_word  = {20'h00000, last_exc_r, 5'h00, dly_r, link_r, isa_r};
  wire logic [31:0]  rd_mux   = (AVS_ADDRESS == REG_CTRL)    ? {27'h0000000, ctrl_r} :
                                (AVS_ADDRESS == REG_STATUS)  ? st_word :
                                (AVS_ADDRESS == REG_BADADDR) ? excb_r :
                                (AVS_ADDRESS == REG_TARGET)  ? tgt_r : 32'h00000000;

  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (t_load) begin
          state_nxt = S_MEM;
        end
      end
      S_MEM: begin
        if (MEM_RSP.valid) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // Register bus slave
  // Waitrequest drops for one cycle per access, then rises again
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
      ctrl_r  <= CTRL_RST;
    end else begin
      wait_r  <= !(bus_req && wait_r);
      rdata_r <= rd_mux;
      if (wr_ctrl) begin
        ctrl_r <= AVS_WRITEDATA[CTRL_W-1:0];
      end
    end
  end

  // Sequencer state
  // Ready stays low while a load is in flight
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state_r <= S_IDLE;
      ready_r <= 1'b1;
      kind_r  <= K_NONE;
      dest_r  <= 5'h00;
      va_r    <= 32'h00000000;
      slot_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= (state_nxt == S_IDLE);
      if (t_load) begin
        kind_r <= kind_dec;
        dest_r <= rt_fld;
        va_r   <= ea;
        slot_r <= dly_r;
      end
    end
  end

  // Memory request, one cycle pulse per load
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      mreq_r <= '0;
    end else begin
      mreq_r.valid <= t_load;
      mreq_r.addr  <= {ea[31:2], ea[1:0] ^ pflip};
      mreq_r.size  <= size_dec;
    end
  end

  // Write back; faulted loads never reach here
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      gwb_r <= '0;
      fwb_r <= '0;
      cwb_r <= '0;
    end else begin
      gwb_r.we   <= rsp_ok && (kind_r <= K_LLW) && (kind_r != K_NONE);
      gwb_r.idx  <= dest_r;
      gwb_r.data <= {32'h00000000, gpr_val};
      fwb_r.we   <= rsp_ok && (kind_r == K_LDF);
      fwb_r.idx  <= dest_r;
      fwb_r.data <= MEM_RSP.data;
      cwb_r.we   <= rsp_ok && (kind_r == K_LOAD_DOUBLE_TO_COP_TWO);
      cwb_r.idx  <= dest_r;
      cwb_r.data <= MEM_RSP.data;
    end
  end

  // Link flag; a new linked load wins over a software clear
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      link_r <= 1'b0;
    end else if (rsp_ok && (kind_r == K_LLW)) begin
      link_r <= 1'b1;
    end else if (clr_link) begin
      link_r <= 1'b0;
    end
  end

  // Jump capture and delayed redirect
  // Any hint value falls back to default handling
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      dly_r       <= 1'b0;
      tgt_r       <= 32'h00000000;
      tgt_fault_r <= 1'b0;
      tgt_isa_r   <= 1'b0;
      isa_r       <= 1'b0;
      pcl_r       <= 1'b0;
      pct_r       <= 32'h00000000;
    end else begin
      pcl_r <= slot_ok;
      if (t_jump && hint_dft) begin
        dly_r       <= 1'b1;
        tgt_r       <= jt_val;
        tgt_fault_r <= jt_fault;
        tgt_isa_r   <= cc_on ? ISSUE_RS_VAL[0] : isa_r;
      end else if (t_jump) begin
        dly_r       <= 1'b1;
        tgt_r       <= jt_val;
        tgt_fault_r <= jt_fault;
        tgt_isa_r   <= cc_on ? ISSUE_RS_VAL[0] : isa_r;
      end else if (slot_ok || slot_err) begin
        dly_r <= 1'b0;
      end
      if (slot_ok) begin
        pct_r <= tgt_r;
        isa_r <= tgt_isa_r;
      end
    end
  end

  // Exception report
  // Fetch errors are raised at redirect time, not at the jump
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      excv_r     <= 1'b0;
      excc_r     <= EXC_NONE;
      excb_r     <= 32'h00000000;
      last_exc_r <= EXC_NONE;
    end else begin
      excv_r <= t_ri || t_cu || t_ade || rsp_flt || (slot_ok && tgt_fault_r);
      if (t_ri) begin
        excc_r     <= EXC_RESERVED;
        last_exc_r <= EXC_RESERVED;
      end else if (t_cu) begin
        excc_r     <= EXC_COP_UNUSE;
        last_exc_r <= EXC_COP_UNUSE;
      end else if (t_ade) begin
        excc_r     <= EXC_ADDR_LOAD;
        excb_r     <= ea;
        last_exc_r <= EXC_ADDR_LOAD;
      end else if (rsp_flt) begin
        excc_r     <= tlb_code;
        excb_r     <= va_r;
        last_exc_r <= tlb_code;
      end else if (slot_ok && tgt_fault_r) begin
        excc_r     <= EXC_ADDR_FET;
        excb_r     <= tgt_r;
        last_exc_r <= EXC_ADDR_FET;
      end
    end
  end

  // Outputs
  assign AVS_READDATA    = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign ISSUE_READY     = ready_r;
  assign MEM_REQ         = mreq_r;
  assign GPR_WB          = gwb_r;
  assign FPR_WB          = fwb_r;
  assign COP2_WB         = cwb_r;
  assign PC_LOAD         = pcl_r;
  assign PC_TARGET       = pct_r;
  assign INSTRUCTION_SET_MODE_BIT        = isa_r;
  assign LINK_FLAG       = link_r;
  assign EXC_VALID       = excv_r;
  assign EXC_CODE        = excc_r;
  assign EXC_BADADDR     = excb_r;

endmodule

`default_nettype wire

// ==== rjl_decode_chk.sv ====
// Purpose: Port assertions for the jump and load slice
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound from the bench top file
`timescale 1ns/10ps
`default_nettype none
module rjl_decode_chk (
  // Clock and reset
  input wire logic                  MCLK,
  input wire logic                  RESET,
  // Issue and memory
  input wire logic                  ISSUE_VALID,
  input wire logic                  ISSUE_READY,
  input wire rjl_pkg::rjl_mem_req_t MEM_REQ,
  input wire rjl_pkg::rjl_mem_rsp_t MEM_RSP,
  // Results
  input wire rjl_pkg::rjl_wb_t      GPR_WB,
  input wire rjl_pkg::rjl_wb_t      FPR_WB,
  input wire rjl_pkg::rjl_wb_t      COP2_WB,
  input wire logic                  PC_LOAD,
  input wire logic [31:0]           PC_TARGET,
  input wire logic                  INSTRUCTION_SET_MODE_BIT,
  input wire logic                  EXC_VALID,
  input wire rjl_pkg::rjl_exc_t     EXC_CODE
);
  import rjl_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  wire logic any_wb = GPR_WB.we | FPR_WB.we | COP2_WB.we;
  wire logic tk     = ISSUE_VALID & ISSUE_READY;
  wire logic tlb    = MEM_RSP.tlb_refill | MEM_RSP.tlb_invalid;
  // Fault steps
  sequence s_addr_err; EXC_VALID && EXC_CODE == EXC_ADDR_LOAD; endsequence
  sequence s_tlb_rsp; MEM_RSP.valid && tlb && !ISSUE_READY; endsequence
  sequence s_tlb_exc;
    EXC_VALID && !any_wb && EXC_CODE == ($past(MEM_RSP.tlb_refill) ? EXC_TLB_REFIL : EXC_TLB_INVAL);
  endsequence
  a_req_follows: assert property (
    MEM_REQ.valid |-> $past(tk)) else $error("request without taken load");
  a_half_align: assert property (
    MEM_REQ.valid && MEM_REQ.size == SZ_HALF |-> !MEM_REQ.addr[0]) else $error("odd halfword request");
  a_dbl_align: assert property (
    MEM_REQ.valid && MEM_REQ.size == SZ_DBL |-> MEM_REQ.addr[2:0] == 3'h0) else $error("odd double request");
  a_err_no_write: assert property (
    s_addr_err |-> !any_wb && !MEM_REQ.valid) else $error("address error with access");
  a_wb_after_rsp: assert property (
    any_wb |-> $past(MEM_RSP.valid) && !$past(tlb)) else $error("write back without good answer");
  a_tlb_no_write: assert property (
    s_tlb_rsp |=> s_tlb_exc) else $error("translation fault not reported");
  a_pc_even: assert property (
    PC_LOAD && INSTRUCTION_SET_MODE_BIT |-> !PC_TARGET[0] && !EXC_VALID) else $error("compressed target wrong");
  a_fetch_err: assert property (
    PC_LOAD && !INSTRUCTION_SET_MODE_BIT |-> EXC_VALID == (PC_TARGET[1:0] != 2'h0) && (!EXC_VALID || EXC_CODE == EXC_ADDR_FET))
    else $error("fetch address error wrong");
  a_slot_first: assert property (
    PC_LOAD |-> any_wb || ($past(tk) && $past(tk, 2))) else $error("redirect before delay slot");
endmodule
`default_nettype wire

// ==== rjl_mem_model.sv ====
// Purpose: Memory side model answering load requests
// Assumes: One request outstanding at a time
// Notes:   Word pattern in the low half, request address in the high half
`timescale 1ns/10ps
`default_nettype none
module rjl_mem_model (
  // Clock and reset
  input  wire logic                  MCLK,
  input  wire logic                  RESET,
  // Latency and fault choice
  input  wire logic [3:0]            lat,
  input  wire logic [1:0]            flt,
  // Request and answer
  input  wire rjl_pkg::rjl_mem_req_t req,
  output var  rjl_pkg::rjl_mem_rsp_t rsp
);
  import rjl_pkg::*;
  localparam logic [31:0] PAT = 32'h80F7_7F01;
  logic        busy_r;
  logic [3:0]  cnt_r;
  logic [31:0] addr_r;
  always_ff @(posedge MCLK) begin
    rsp <= {1'b0, ~rsp.data, 2'h0};
    if (RESET) begin
      busy_r <= 1'b0;
      rsp    <= '0;
    end else if (req.valid) begin
      busy_r <= 1'b1;
      cnt_r  <= lat;
      addr_r <= req.addr;
    end else if (busy_r && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (busy_r) begin
      busy_r <= 1'b0;
      rsp    <= {1'b1, addr_r, PAT, flt};
    end
  end
endmodule
`default_nettype wire

// ==== rjl_decode_bench.sv ====
// Purpose: Self-checking bench for the jump and load slice
// Assumes: Memory model answers each request once
// Notes:   A monitor counts pulses; each task judges its own
`timescale 1ns/10ps
`default_nettype none
module rjl_decode_bench;
  import rjl_pkg::*;
  localparam logic [31:0] PAT = 32'h80F7_7F01;
  logic         MCLK = 1'b0, RESET = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0, ISSUE_VALID = 1'b0;
  logic [3:0]   AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hF, lat = 4'h0;
  logic [31:0]  AVS_WRITEDATA = 32'h0, ISSUE_INSTR = 32'h0, ISSUE_RS_VAL = 32'h0;
  logic [1:0]   flt = 2'h0;
  logic [31:0]  AVS_READDATA, PC_TARGET, EXC_BADADDR, pc_s, q;
  logic         AVS_WAITREQUEST, ISSUE_READY, PC_LOAD, INSTRUCTION_SET_MODE_BIT, LINK_FLAG, EXC_VALID, isa_s;
  logic [2:0]   wbk_s;
  rjl_mem_req_t MEM_REQ, req_s;
  rjl_mem_rsp_t MEM_RSP;
  rjl_wb_t      GPR_WB, FPR_WB, COP2_WB, wb_s;
  rjl_exc_t     EXC_CODE, exc_s;
  int           err_count, checks_done, n_wb, n_exc, n_pc, n_req;
  initial begin
    forever #4 MCLK = ~MCLK;
  end
  rjl_decode u_rjl_decode (.MCLK, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .ISSUE_VALID, .ISSUE_INSTR, .ISSUE_RS_VAL,
    .ISSUE_READY, .MEM_REQ, .MEM_RSP, .GPR_WB, .FPR_WB, .COP2_WB, .PC_LOAD, .PC_TARGET,
    .INSTRUCTION_SET_MODE_BIT, .LINK_FLAG, .EXC_VALID, .EXC_CODE, .EXC_BADADDR);
  rjl_mem_model u_rjl_mem_model (.MCLK, .RESET, .lat, .flt, .req(MEM_REQ), .rsp(MEM_RSP));
  // Pulse monitor
  always @(posedge MCLK) begin
    if (GPR_WB.we || FPR_WB.we || COP2_WB.we) begin
      n_wb++;
      wbk_s = {GPR_WB.we, FPR_WB.we, COP2_WB.we};
      wb_s = GPR_WB.we ? GPR_WB : (FPR_WB.we ? FPR_WB : COP2_WB);
    end
    if (EXC_VALID) begin
      n_exc++;
      exc_s = EXC_CODE;
    end
    if (PC_LOAD) begin
      n_pc++;
      pc_s = PC_TARGET;
      isa_s = INSTRUCTION_SET_MODE_BIT;
    end
    if (MEM_REQ.valid) begin
      n_req++;
      req_s = MEM_REQ;
    end
  end
  task automatic wrap_up();
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    AVS_WRITEDATA <= d;
    do @(posedge MCLK);
    while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    avs(1'b0, a, 32'h0);
    cmp(q, exp);
  endtask
  task automatic issue(input logic [31:0] ins, input logic [31:0] rs);
    ISSUE_VALID <= 1'b1;
    ISSUE_INSTR <= ins;
    ISSUE_RS_VAL <= rs;
    do @(posedge MCLK);
    while (ISSUE_READY !== 1'b1);
  endtask
  // Base is ea plus 16, offset is minus 16
  task automatic ld(input logic [5:0] op, input logic [31:0] ea, input rjl_exc_t ee,
                    input logic [2:0] ek, input logic [63:0] ed, input logic [31:0] ma);
    int w, x, r, n;
    w = n_wb;
    x = n_exc;
    r = n_req;
    issue({op, 5'd1, 5'd7, 16'hFFF0}, ea + 32'h10);
    ISSUE_VALID <= 1'b0;
    n = 0;
    do @(negedge MCLK);
    while (n_wb == w && n_exc == x && ++n < 40);
    cmp(n_exc - x, ee != EXC_NONE);
    cmp(n_wb - w, ee == EXC_NONE);
    cmp(n_req - r, ee inside {EXC_NONE, EXC_TLB_REFIL, EXC_TLB_INVAL});
    if (ee != EXC_NONE) begin
      cmp(exc_s, ee);
      if (ee inside {EXC_ADDR_LOAD, EXC_TLB_REFIL, EXC_TLB_INVAL}) begin
        cmp(EXC_BADADDR, ea);
      end
    end else begin
      cmp({wbk_s, wb_s.idx}, {ek, 5'd7});
      cmp(wb_s.data, ed);
      cmp(req_s.addr, ma);
    end
    @(posedge MCLK);
  endtask
  task automatic t_regs();
    rd_chk(REG_CTRL, 32'h18);
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(4'h2, 32'h0);
    avs(1'b1, REG_CTRL, 32'h7);
    rd_chk(REG_CTRL, 32'h7);
    AVS_BYTEENABLE <= 4'h0;
    avs(1'b1, REG_CTRL, 32'h0);
    AVS_BYTEENABLE <= 4'hF;
    rd_chk(REG_CTRL, 32'h7);
    avs(1'b1, REG_TARGET, 32'hFFFF_FFFF);
    rd_chk(REG_TARGET, 32'h0);
  endtask
  task automatic t_bytes();
    logic [1:0] ln;
    logic [7:0] b;
    for (int m = 0; m < 8; m++) begin
      avs(1'b1, REG_CTRL, {29'h3, m[2], m[1], 1'b0});
      for (int va = 0; va < 4; va++) begin
        ln = va[1:0] ^ {2{m[1]}};
        b = PAT[8*ln +: 8];
        ld(m[0] ? u_rjl_decode.P_OP_LBS : u_rjl_decode.P_OP_LBU, 32'h1FF0 + va, EXC_NONE, 3'b100,
           {32'h0, m[0] ? {{24{b[7]}}, b} : {24'h0, b}}, {30'h7FC, va[1:0] ^ {2{m[2]}}});
      end
    end
  endtask
  task automatic t_halves();
    logic [1:0]  ln;
    logic [15:0] h;
    for (int m = 0; m < 8; m++) begin
      avs(1'b1, REG_CTRL, {29'h3, m[2], m[1], 1'b0});
      for (int va = 0; va < 4; va++) begin
        ln = va[1:0] ^ {m[1], 1'b0};
        h = PAT[16*ln[1] +: 16];
        ld(m[0] ? u_rjl_decode.P_OP_LHS : u_rjl_decode.P_OP_LHU, 32'h1FF0 + va,
           va[0] ? EXC_ADDR_LOAD : EXC_NONE, 3'b100, {32'h0, m[0] ? {{16{h[15]}}, h} : {16'h0, h}},
           {30'h7FC, va[1] ^ m[2], va[0]});
      end
    end
  endtask
  task automatic t_dbl();
    avs(1'b1, REG_CTRL, 32'h18);
    lat <= 4'h6;
    ld(OP_LOAD_DFP, 32'h2FF8, EXC_NONE, 3'b010, {32'h2FF8, PAT}, 32'h2FF8);
    ld(OP_LOAD_DC2, 32'h2FF8, EXC_NONE, 3'b001, {32'h2FF8, PAT}, 32'h2FF8);
    ld(OP_LOAD_DFP, 32'h2FFC, EXC_ADDR_LOAD, 3'b0, 64'h0, 32'h0);
    ld(OP_LOAD_DC2, 32'h2FF9, EXC_ADDR_LOAD, 3'b0, 64'h0, 32'h0);
    avs(1'b1, REG_CTRL, 32'h0);
    ld(OP_LOAD_DFP, 32'h2FF8, EXC_COP_UNUSE, 3'b0, 64'h0, 32'h0);
    ld(OP_LOAD_DC2, 32'h2FF8, EXC_COP_UNUSE, 3'b0, 64'h0, 32'h0);
    avs(1'b1, REG_CTRL, 32'h18);
    flt <= 2'b10;
    ld(OP_LOAD_DFP, 32'h2FF8, EXC_TLB_REFIL, 3'b0, 64'h0, 32'h0);
    flt <= 2'b01;
    ld(u_rjl_decode.P_OP_LBS, 32'h2FF3, EXC_TLB_INVAL, 3'b0, 64'h0, 32'h0);
    flt <= 2'b00;
    lat <= 4'h0;
  endtask
  task automatic t_link();
    ld(OP_LOAD_LL, 32'h4004, EXC_NONE, 3'b100, {32'h0, PAT}, 32'h4004);
    @(negedge MCLK);
    cmp(LINK_FLAG, 1'b1);
    @(posedge MCLK);
    avs(1'b1, REG_STATUS, 32'h2);
    ld(OP_LOAD_LL, 32'h4006, EXC_ADDR_LOAD, 3'b0, 64'h0, 32'h0);
    ld(OP_LOAD_LL, 32'h4005, EXC_ADDR_LOAD, 3'b0, 64'h0, 32'h0);
    @(negedge MCLK);
    cmp(LINK_FLAG, 1'b0);
    @(posedge MCLK);
    rd_chk(REG_STATUS, 32'h100);
    rd_chk(REG_BADADDR, 32'h4005);
  endtask
  task automatic t_jump(input logic [4:0] c, input logic [9:0] z, input logic [31:0] rs, input logic [4:0] hint,
                        input logic [31:0] ep, input logic ei, input rjl_exc_t ee);
    int p, x;
    avs(1'b1, REG_CTRL, {27'h0, c});
    p = n_pc;
    x = n_exc;
    issue({OP_FUNC_GROUP, 5'd2, z, hint, FN_JUMP_REG}, rs);
    if (z == JR_ZERO_FIELD) begin
      issue(32'h0, 32'h0);
    end
    ISSUE_VALID <= 1'b0;
    repeat (3) @(negedge MCLK);
    cmp(n_pc - p, z == JR_ZERO_FIELD);
    cmp(n_exc - x, ee != EXC_NONE);
    if (ee != EXC_NONE) begin
      cmp(exc_s, ee);
    end
    if (z == JR_ZERO_FIELD) begin
      cmp({pc_s, isa_s}, {ep, ei});
    end
    @(posedge MCLK);
    if (z == JR_ZERO_FIELD) begin
      rd_chk(REG_TARGET, ep);
    end
  endtask
  initial begin
    repeat (8) @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
    t_regs();
    t_bytes();
    t_halves();
    t_dbl();
    t_link();
    t_jump(5'h18, 10'h0, 32'h2000_0008, 5'h00, 32'h2000_0008, 1'b0, EXC_NONE);
    t_jump(5'h18, 10'h0, 32'h2000_000A, 5'h03, 32'h2000_000A, 1'b0, EXC_ADDR_FET);
    t_jump(5'h18, 10'h0, 32'h2000_0009, 5'h00, 32'h2000_0009, 1'b0, EXC_ADDR_FET);
    t_jump(5'h19, 10'h0, 32'h2000_0002, 5'h00, 32'h2000_0002, 1'b0, EXC_ADDR_FET);
    t_jump(5'h19, 10'h0, 32'h2000_0005, 5'h00, 32'h2000_0004, 1'b1, EXC_NONE);
    t_jump(5'h19, 10'h0, 32'h2000_0007, 5'h00, 32'h2000_0006, 1'b1, EXC_NONE);
    t_jump(5'h19, 10'h001, 32'h2000_0008, 5'h00, 32'h0, 1'b0, EXC_RESERVED);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge MCLK);
    err_count++;
    wrap_up();
  end
endmodule
bind rjl_decode rjl_decode_chk u_rjl_decode_chk (.MCLK, .RESET, .ISSUE_VALID, .ISSUE_READY, .MEM_REQ,
  .MEM_RSP, .GPR_WB, .FPR_WB, .COP2_WB, .PC_LOAD, .PC_TARGET, .INSTRUCTION_SET_MODE_BIT, .EXC_VALID, .EXC_CODE);
`default_nettype wire
